// ---- core/svd_core.sv ----
// supply detector control, status, trip flag and interrupt request with avalon-mm slave
// How it works
// - four-bit trip level field in control
// - code 1111 selects external detect input
// - bit 4 powers and enables detector
// - read-only reference stable flag bit 5
// - control bits 7-6 read zero
// - trip below set point sets flag
// - enabled flag requests interrupt vector branch
// - stabilization interval after every enable
// - flag meaningless until stable flag set
// - flag held off until reference stable
// - detector runs in sleep, trip wakes when its own irq enable is set
// - reset returns all fields, detector off
//
// The Avalon-MM register port and the register addresses are this design's own decisions.
module svd_core
    import svd_pkg::*;
#(
    parameter int SETTLE_CYC = SVD_SETTLE_CYC
)
(
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    input  wire logic [3:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic [31:0]      avs_readdata_o,
    output logic             avs_waitrequest_o,
    output logic [1:0]       avs_response_o,
    input  wire logic        comp_below_i,
    input  wire logic        sleep_i,
    output logic             supply_detector_power_o,
    output logic             ext_input_sel_o,
    output logic [3:0]       trip_level_select_o,
    output logic             irq_o,
    output logic             wake_o
);
    logic [3:0]           trip_level_select_ff;
    logic                 detector_power_enable_ff;
    logic                 reference_stable_flag_ff;
    logic                 low_voltage_irq_flag_ff;
    logic                 low_voltage_irq_enable_ff;
    logic                 global_irq_enable_ff;
    logic [SVD_CNT_W-1:0] settle_cnt_ff;
    logic                 comp_meta_ff;
    logic                 comp_sync_ff;
    logic                 ack_ff;
    logic [31:0]          rdata_ff;
    logic [1:0]           resp_ff;
    logic                 req;
    logic                 wr_go;
    logic                 flag_clr;
    logic                 trip;

    function automatic logic hit(input logic [3:0] a, input logic [3:0] offs);
        return a == offs;
    endfunction

    // one wait cycle per access keeps read data registered
    assign req               = (avs_read_i || avs_write_i) && !ack_ff;
    assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_ff;
    assign wr_go             = avs_write_i && !ack_ff && avs_byteenable_i[0];
    assign avs_readdata_o    = rdata_ff;
    assign avs_response_o    = resp_ff;

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            ack_ff <= 1'b0;
        else
            ack_ff <= req;
    end

    // the comparator output is analog-side, so synchronise it
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            comp_meta_ff <= 1'b0;
            comp_sync_ff <= 1'b0;
        end
        else
        begin
            comp_meta_ff <= comp_below_i;
            comp_sync_ff <= comp_meta_ff;
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            trip_level_select_ff     <= SVD_LVL_RST;
            detector_power_enable_ff <= 1'b0;
        end
        else if (wr_go && hit(avs_address_i, SVD_CTRL_OFFS))
        begin
            trip_level_select_ff     <= avs_writedata_i[SVD_LVL_LSB +: SVD_LVL_W];
            detector_power_enable_ff <= avs_writedata_i[SVD_EN_BIT];
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            low_voltage_irq_enable_ff <= 1'b0;
            global_irq_enable_ff      <= 1'b0;
        end
        else if (wr_go && hit(avs_address_i, SVD_IRQEN_OFFS))
        begin
            low_voltage_irq_enable_ff <= avs_writedata_i[SVD_LIE_BIT];
            global_irq_enable_ff      <= avs_writedata_i[SVD_GIE_BIT];
        end
    end

    // settle counter restarts on every enable
    always_ff @(posedge mclk_i)
    begin
        if (rst_i || !detector_power_enable_ff)
        begin
            settle_cnt_ff            <= '0;
            reference_stable_flag_ff <= 1'b0;
        end
        else if (settle_cnt_ff == SVD_CNT_W'(SETTLE_CYC - 1))
            reference_stable_flag_ff <= 1'b1;
        else
            settle_cnt_ff <= settle_cnt_ff + 1'b1;
    end

    // trip only counts once the reference is stable
    assign trip     = detector_power_enable_ff && reference_stable_flag_ff && comp_sync_ff;
    // write one to status bit 0 clears the flag
    assign flag_clr = wr_go && hit(avs_address_i, SVD_STAT_OFFS)
                      && avs_writedata_i[SVD_FLAG_BIT];

    // sticky flag, a new trip beats a clear
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            low_voltage_irq_flag_ff <= 1'b0;
        else if (trip)
            low_voltage_irq_flag_ff <= 1'b1;
        else if (flag_clr)
            low_voltage_irq_flag_ff <= 1'b0;
    end

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            rdata_ff <= '0;
            resp_ff  <= 2'h0;
        end
        else if (req && avs_read_i)
        begin
            resp_ff <= 2'h0;
            unique case (avs_address_i)
                SVD_CTRL_OFFS:
                    rdata_ff <= {24'h0, 2'h0, reference_stable_flag_ff,
                                 detector_power_enable_ff, trip_level_select_ff};
                SVD_STAT_OFFS:
                    rdata_ff <= {30'h0, comp_sync_ff, low_voltage_irq_flag_ff};
                SVD_IRQEN_OFFS:
                    rdata_ff <= {30'h0, global_irq_enable_ff, low_voltage_irq_enable_ff};
                default:
                begin
                    rdata_ff <= '0;
                    resp_ff  <= 2'h2;
                end
            endcase
        end
        else if (req)
        begin
            rdata_ff <= '0;
            resp_ff  <= (hit(avs_address_i, SVD_CTRL_OFFS) || hit(avs_address_i, SVD_STAT_OFFS)
                         || hit(avs_address_i, SVD_IRQEN_OFFS)) ? 2'h0 : 2'h2;
        end
    end

    assign supply_detector_power_o = detector_power_enable_ff;
    assign ext_input_sel_o         = (trip_level_select_ff == SVD_LVL_EXT);
    assign trip_level_select_o     = trip_level_select_ff;
    assign irq_o  = low_voltage_irq_flag_ff && low_voltage_irq_enable_ff && global_irq_enable_ff;
    // a set flag wakes during sleep when its enable is set, regardless of global enable
    assign wake_o = low_voltage_irq_flag_ff && low_voltage_irq_enable_ff && sleep_i;

    property p_settle;
        @(posedge mclk_i) disable iff (rst_i)
        $rose(reference_stable_flag_ff) |-> settle_cnt_ff == SVD_CNT_W'(SETTLE_CYC - 1);
    endproperty
    a_settle: assert property (p_settle) else $error("stable flag early");

    property p_restart;
        @(posedge mclk_i) disable iff (rst_i)
        !detector_power_enable_ff |=> settle_cnt_ff == '0;
    endproperty
    a_restart: assert property (p_restart) else $error("settle count kept");

    property p_off_clear;
        @(posedge mclk_i) disable iff (rst_i)
        !detector_power_enable_ff |=> !reference_stable_flag_ff;
    endproperty
    a_off_clear: assert property (p_off_clear) else $error("stable flag while off");

    property p_hold;
        @(posedge mclk_i) disable iff (rst_i)
        !reference_stable_flag_ff && !low_voltage_irq_flag_ff |=> !low_voltage_irq_flag_ff;
    endproperty
    a_hold: assert property (p_hold) else $error("flag before stable");

    property p_trip;
        @(posedge mclk_i) disable iff (rst_i)
        trip |=> low_voltage_irq_flag_ff;
    endproperty
    a_trip: assert property (p_trip) else $error("trip lost");

    property p_clr;
        @(posedge mclk_i) disable iff (rst_i)
        flag_clr && !trip |=> !low_voltage_irq_flag_ff;
    endproperty
    a_clr: assert property (p_clr) else $error("flag clear lost");

    property p_irq;
        @(posedge mclk_i) disable iff (rst_i)
        irq_o |-> low_voltage_irq_enable_ff && global_irq_enable_ff && low_voltage_irq_flag_ff;
    endproperty
    a_irq: assert property (p_irq) else $error("irq without enables");

    property p_wake;
        @(posedge mclk_i) disable iff (rst_i)
        wake_o |-> low_voltage_irq_flag_ff && low_voltage_irq_enable_ff;
    endproperty
    a_wake: assert property (p_wake) else $error("wake without flag");

    property p_ext;
        @(posedge mclk_i) disable iff (rst_i)
        ext_input_sel_o == (trip_level_select_o == 4'hf);
    endproperty
    a_ext: assert property (p_ext) else $error("external select wrong");

    property p_rd;
        @(posedge mclk_i) disable iff (rst_i)
        avs_read_i && !avs_waitrequest_o && hit(avs_address_i, SVD_CTRL_OFFS)
            |-> avs_readdata_o[7:6] == 2'h0 && avs_readdata_o[5] == $past(reference_stable_flag_ff);
    endproperty
    a_rd: assert property (p_rd) else $error("control readback wrong");

    property p_hi_zero;
        @(posedge mclk_i) disable iff (rst_i)
        avs_read_i && !avs_waitrequest_o && hit(avs_address_i, SVD_CTRL_OFFS)
            |-> avs_readdata_o[31:6] == 26'h0;
    endproperty
    a_hi_zero: assert property (p_hi_zero) else $error("upper control bits set");

    property p_wr;
        @(posedge mclk_i) disable iff (rst_i)
        wr_go && hit(avs_address_i, SVD_CTRL_OFFS)
            |=> detector_power_enable_ff == $past(avs_writedata_i[4]);
    endproperty
    a_wr: assert property (p_wr) else $error("enable write lost");

    property p_lvl;
        @(posedge mclk_i) disable iff (rst_i)
        wr_go && hit(avs_address_i, SVD_CTRL_OFFS)
            |=> trip_level_select_ff == $past(avs_writedata_i[SVD_LVL_LSB +: SVD_LVL_W]);
    endproperty
    a_lvl: assert property (p_lvl) else $error("level write lost");

    property p_rst;
        @(posedge mclk_i) rst_i |=> !detector_power_enable_ff && trip_level_select_ff == 4'h5;
    endproperty
    a_rst: assert property (p_rst) else $error("reset values wrong");

    // main scenarios reached
    c_stable: cover property (@(posedge mclk_i) $rose(reference_stable_flag_ff));
    c_irq:    cover property (@(posedge mclk_i) $rose(irq_o));
    c_ext:    cover property (@(posedge mclk_i) ext_input_sel_o && trip);
    c_wake:   cover property (@(posedge mclk_i) $rose(wake_o));
    c_clr:    cover property (@(posedge mclk_i) flag_clr && low_voltage_irq_flag_ff && !trip);
endmodule

// ---- core/svd_pkg.sv ----
// package: register map, field layout, reset values and timing of the supply detector
package svd_pkg;
    // register byte addresses (word aligned)
    localparam logic [3:0] SVD_CTRL_OFFS   = 4'h0;
    localparam logic [3:0] SVD_STAT_OFFS   = 4'h4;
    localparam logic [3:0] SVD_IRQEN_OFFS  = 4'h8;
    // control register fields
    localparam int         SVD_LVL_LSB     = 0;
    localparam int         SVD_LVL_W       = 4;
    localparam int         SVD_EN_BIT      = 4;
    localparam int         SVD_STABLE_BIT  = 5;
    // status register fields
    localparam int         SVD_FLAG_BIT    = 0;
    localparam int         SVD_TRIP_BIT    = 1;
    // irq enable register fields
    localparam int         SVD_LIE_BIT     = 0;
    localparam int         SVD_GIE_BIT     = 1;
    // reset values; the trip code resets to 0101
    localparam logic [3:0] SVD_LVL_RST     = 4'h5;
    localparam logic [3:0] SVD_LVL_EXT     = 4'hf;
    localparam logic [3:0] SVD_LVL_RSVD    = 4'h0;
    localparam logic [7:0] SVD_CTRL_MASK   = 8'h1f;
    // reference settling time
    localparam int         SVD_CLK_MHZ     = 200;
    localparam int         SVD_SETTLE_US   = 20;
    localparam int         SVD_SETTLE_CYC  = SVD_SETTLE_US * SVD_CLK_MHZ;
    localparam int         SVD_CNT_W       = 16;
endpackage

// ---- sim/svd_core_tb.sv ----
// register-level testbench of the supply detector over avalon-mm
module svd_core_tb
    import svd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [3:0]  avs_address_i = 4'h0;
    logic        avs_read_i = 1'b0;
    logic        avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [3:0]  avs_byteenable_i = 4'hf;
    logic [31:0] avs_readdata_o;
    logic        avs_waitrequest_o;
    logic [1:0]  avs_response_o;
    logic        comp_below_i = 1'b0;
    logic        sleep_i = 1'b0;
    logic        supply_detector_power_o;
    logic        ext_input_sel_o;
    logic [3:0]  trip_level_select_o;
    logic        irq_o;
    logic        wake_o;
    logic [31:0] rd_q;
    logic [1:0]  rsp_q;
    int          error_cnt = 0;
    int          num_checks = 0;
    int          cyc = 0;
    localparam logic [31:0] CTRL_RST = {28'h0, SVD_LVL_RST};
    svd_core #(.SETTLE_CYC(8)) u_svd_core (.mclk_i(mclk_i), .rst_i(rst_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .avs_response_o(avs_response_o), .comp_below_i(comp_below_i), .sleep_i(sleep_i),
        .supply_detector_power_o(supply_detector_power_o), .ext_input_sel_o(ext_input_sel_o),
        .trip_level_select_o(trip_level_select_o), .irq_o(irq_o), .wake_o(wake_o));
    initial
    begin
        forever #2.5 mclk_i = ~mclk_i;
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // a hung handshake must not stall the run forever
    always @(posedge mclk_i)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            error_cnt++;
            final_report();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    // request held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                       input logic [3:0] be);
        @(posedge mclk_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_byteenable_i <= be;
        avs_write_i <= w;
        avs_read_i <= !w;
        do @(posedge mclk_i); while (avs_waitrequest_o !== 1'b0);
        rd_q = avs_readdata_o;
        rsp_q = avs_response_o;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hf);
    endtask
    task automatic rdc(input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, 4'hf);
        chk(rd_q, e);
    endtask
    task automatic do_reset();
        @(posedge mclk_i);
        rst_i <= 1'b1;
        repeat (12) @(posedge mclk_i);
        rst_i <= 1'b0;
    endtask
    // pin levels change only on a rising edge
    task automatic drv_in(input logic comp, input logic slp);
        @(posedge mclk_i);
        comp_below_i <= comp;
        sleep_i <= slp;
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    initial
    begin
        do_reset();
        rdc(SVD_CTRL_OFFS, CTRL_RST);
        chk({30'h0, supply_detector_power_o, irq_o}, 32'h0);
        $display("test reset values done");
        for (int c = 1; c < 16; c++)
        begin
            wr(SVD_CTRL_OFFS, 32'(c) | 32'hc0);
            chk({27'h0, ext_input_sel_o, trip_level_select_o}, {27'h0, c == 15, 4'(c)});
            rdc(SVD_CTRL_OFFS, 32'(c));
        end
        $display("test trip codes done");
        bus(1'b1, SVD_CTRL_OFFS, 32'h1e, 4'he);
        rdc(SVD_CTRL_OFFS, 32'h0f);
        bus(1'b0, 4'hc, 32'h0, 4'hf);
        chk({rsp_q, rd_q[29:0]}, 32'h80000000);
        $display("test refused access done");
        // level and enable, settle, clear, then irq enable
        drv_in(1'b1, 1'b0);
        wr(SVD_CTRL_OFFS, 32'h3e);
        chk({31'h0, supply_detector_power_o}, 32'h1);
        rdc(SVD_CTRL_OFFS, 32'h1e);
        bus(1'b0, SVD_STAT_OFFS, 32'h0, 4'hf);
        chk({31'h0, rd_q[0]}, 32'h0);
        wait_cyc(12);
        rdc(SVD_CTRL_OFFS, 32'h3e);
        rdc(SVD_STAT_OFFS, 32'h3);
        // set wins over a clear while still below the set point
        wr(SVD_STAT_OFFS, 32'h1);
        rdc(SVD_STAT_OFFS, 32'h3);
        wr(SVD_IRQEN_OFFS, 32'h3);
        chk({31'h0, irq_o}, 32'h1);
        wr(SVD_IRQEN_OFFS, 32'h1);
        chk({30'h0, irq_o, wake_o}, 32'h0);
        drv_in(1'b1, 1'b1);
        wait_cyc(1);
        chk({31'h0, wake_o}, 32'h1);
        drv_in(1'b0, 1'b1);
        wait_cyc(4);
        wr(SVD_STAT_OFFS, 32'h1);
        rdc(SVD_STAT_OFFS, 32'h0);
        chk({31'h0, wake_o}, 32'h0);
        drv_in(1'b0, 1'b0);
        $display("test flag and irq done");
        drv_in(1'b1, 1'b0);
        wr(SVD_CTRL_OFFS, 32'h0e);
        wait_cyc(6);
        rdc(SVD_CTRL_OFFS, 32'h0e);
        chk({31'h0, supply_detector_power_o}, 32'h0);
        bus(1'b0, SVD_STAT_OFFS, 32'h0, 4'hf);
        chk({31'h0, rd_q[0]}, 32'h0);
        $display("test disable done");
        wr(SVD_CTRL_OFFS, 32'h1a);
        wait_cyc(12);
        rdc(SVD_STAT_OFFS, 32'h3);
        do_reset();
        rdc(SVD_CTRL_OFFS, CTRL_RST);
        rdc(SVD_IRQEN_OFFS, 32'h0);
        rdc(SVD_STAT_OFFS, 32'h2);
        chk({31'h0, supply_detector_power_o}, 32'h0);
        $display("test mid-run reset done");
        final_report();
    end
endmodule
